// *** logic/fault_sup_pkg.sv ***
`default_nettype none
package fault_sup_pkg;
    // clock period of the supervisor in ns
    localparam int CLK_PERIOD_NS = 20;

    // supply lockout lag: least time, rounded up
    localparam int LOCKOUT_LAG_NS = 1000;
    localparam int LOCKOUT_LAG_CYC =
        (LOCKOUT_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LAG_W = 8;

    // enable/dim low time that clears latched faults
    localparam int LATCH_CLEAR_MS = 16;
    localparam int LATCH_CLEAR_CYC =
        (LATCH_CLEAR_MS * 1000000) / CLK_PERIOD_NS;
    // shutdown low time; no figure is printed, plain default
    localparam int SHUTDOWN_LOW_CYC = LATCH_CLEAR_CYC;

    localparam int LOW_CNT_W = 20;
    localparam logic [LOW_CNT_W-1:0] LOW_CNT_ZERO = 20'h00000;
    localparam logic [LOW_CNT_W-1:0] LOW_CNT_ONE = 20'h00001;
    localparam logic [LOW_CNT_W-1:0] LOW_CNT_MAX = 20'hfffff;

    // comparator conditions seen by the supervisor
    typedef struct packed {
        logic output_high_threshold;     // output overvoltage sense high
        logic led_in_regulation;         // led current regulated
        logic output_undervoltage_detect; // sense below 110 mV
        logic drain_overvoltage_threshold; // boost drain node too high
        logic primary_switch_limit;      // cycle-by-cycle limit tripped
        logic secondary_switch_limit;    // higher limit tripped
        logic current_program_over;      // program current above 150%
        logic thermal_shutdown_level;    // die too hot
        logic led_pin_short;             // led pin shorted to ground
    } sense_t;

    typedef struct packed {
        logic lockout_rising_level;  // supply above rising threshold
        logic lockout_falling_level; // supply below falling threshold
        logic regulator_alive;       // internal regulator still running
    } supply_t;

    typedef enum logic [3:0] {
        MODE_LOCKED   = 4'h1,
        MODE_SHUTDOWN = 4'h2,
        MODE_STARTUP  = 4'h4,
        MODE_RUN      = 4'h8
    } mode_t;
endpackage
`default_nettype wire

// *** logic/persist_filter.sv ***
`default_nettype none
// flags a condition that has held for more than LIMIT cycles
module persist_filter #(
    parameter logic [fault_sup_pkg::LAG_W-1:0] LIMIT = 8'h32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cond,
    output logic over_ff
);
    logic [fault_sup_pkg::LAG_W-1:0] cnt_ff;

    always_ff @(posedge clk)
    begin
        if (rst)
            cnt_ff <= '0;
        else if (!cond)
            cnt_ff <= '0;
        else if (cnt_ff < LIMIT)
            cnt_ff <= cnt_ff + 8'h01;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            over_ff <= 1'b0;
        else
            over_ff <= cond && (cnt_ff >= LIMIT);
    end
endmodule
`default_nettype wire

// *** logic/led_fault_supervisor.sv ***
`default_nettype none
module led_fault_supervisor #(
    parameter logic [fault_sup_pkg::LOW_CNT_W-1:0] SHUTDOWN_CYCLES =
        fault_sup_pkg::LOW_CNT_W'(fault_sup_pkg::SHUTDOWN_LOW_CYC),
    parameter logic [fault_sup_pkg::LOW_CNT_W-1:0] CLEAR_CYCLES =
        fault_sup_pkg::LOW_CNT_W'(fault_sup_pkg::LATCH_CLEAR_CYC)
) (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic ENABLE_DIM,
    input wire fault_sup_pkg::sense_t SENSE,
    input wire fault_sup_pkg::supply_t SUPPLY,
    input wire logic CYCLE_START,
    input wire logic SOFT_START_DONE,
    output logic BOOST_ON,
    output logic SINK_ON,
    output logic FAULT_N,
    output logic SHUTDOWN,
    output fault_sup_pkg::mode_t MODE
);
    localparam logic [fault_sup_pkg::LAG_W-1:0] LAG_LIMIT =
        fault_sup_pkg::LAG_W'(fault_sup_pkg::LOCKOUT_LAG_CYC);

    fault_sup_pkg::mode_t mode_ff;
    fault_sup_pkg::mode_t nxt_mode;
    logic fall_lag;
    logic lockout_ff;
    logic en_prev_ff;
    logic [fault_sup_pkg::LOW_CNT_W-1:0] low_cnt_ff;
    logic low_shutdown;
    logic low_clear;
    logic latch_clear;
    logic open_latch_ff;
    logic drain_latch_ff;
    logic seclim_latch_ff;
    logic skip_cycle_ff;
    logic startup;
    logic short_block;
    logic latched_any;
    logic auto_stop;
    logic all_off;
    logic flag_on;

    persist_filter #(
        .LIMIT(LAG_LIMIT)
    ) u_lockout_lag (
        .clk(REF_CLK),
        .rst(RESET),
        .cond(SUPPLY.lockout_falling_level),
        .over_ff(fall_lag)
    );

    // lockout holds from reset until the supply crosses the rising level
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            lockout_ff <= 1'b1;
        else if (fall_lag)
            lockout_ff <= 1'b1;
        else if (SUPPLY.lockout_rising_level)
            lockout_ff <= 1'b0;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            en_prev_ff <= 1'b0;
        else
            en_prev_ff <= ENABLE_DIM;
    end

    // low time, restarted whenever the input is high
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            low_cnt_ff <= fault_sup_pkg::LOW_CNT_ZERO;
        else if (ENABLE_DIM)
            low_cnt_ff <= fault_sup_pkg::LOW_CNT_ZERO;
        else if (low_cnt_ff != fault_sup_pkg::LOW_CNT_MAX)
            low_cnt_ff <= low_cnt_ff + fault_sup_pkg::LOW_CNT_ONE;
    end

    assign low_shutdown = !ENABLE_DIM && (low_cnt_ff >= SHUTDOWN_CYCLES);
    assign low_clear = !ENABLE_DIM && (low_cnt_ff >= CLEAR_CYCLES);
    assign latch_clear = lockout_ff || low_shutdown || low_clear;
    assign startup = (mode_ff == fault_sup_pkg::MODE_STARTUP);

    always_comb
    begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            fault_sup_pkg::MODE_LOCKED:
                if (!lockout_ff)
                    nxt_mode = ENABLE_DIM ? fault_sup_pkg::MODE_STARTUP
                                          : fault_sup_pkg::MODE_SHUTDOWN;
            fault_sup_pkg::MODE_SHUTDOWN:
                if (ENABLE_DIM)
                    nxt_mode = fault_sup_pkg::MODE_STARTUP;
            fault_sup_pkg::MODE_STARTUP:
                if (low_shutdown)
                    nxt_mode = fault_sup_pkg::MODE_SHUTDOWN;
                else if (SOFT_START_DONE && ENABLE_DIM && !short_block)
                    nxt_mode = fault_sup_pkg::MODE_RUN;
            fault_sup_pkg::MODE_RUN:
                if (low_shutdown)
                    nxt_mode = fault_sup_pkg::MODE_SHUTDOWN;
            default:
                nxt_mode = fault_sup_pkg::MODE_LOCKED;
        endcase
        if (lockout_ff)
            nxt_mode = fault_sup_pkg::MODE_LOCKED;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            mode_ff <= fault_sup_pkg::MODE_LOCKED;
        else
            mode_ff <= nxt_mode;
    end

    // latched faults: a new event wins over a clear in the same cycle
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            open_latch_ff <= 1'b0;
        else if (SENSE.output_high_threshold && !SENSE.led_in_regulation
                 && !startup)
            open_latch_ff <= 1'b1;
        else if (latch_clear)
            open_latch_ff <= 1'b0;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            drain_latch_ff <= 1'b0;
        else if (SENSE.drain_overvoltage_threshold)
            drain_latch_ff <= 1'b1;
        else if (latch_clear)
            drain_latch_ff <= 1'b0;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            seclim_latch_ff <= 1'b0;
        else if (SENSE.secondary_switch_limit)
            seclim_latch_ff <= 1'b1;
        else if (latch_clear)
            seclim_latch_ff <= 1'b0;
    end

    // boost held off until the next switching cycle starts
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            skip_cycle_ff <= 1'b0;
        else if (SENSE.primary_switch_limit)
            skip_cycle_ff <= 1'b1;
        else if (CYCLE_START)
            skip_cycle_ff <= 1'b0;
    end

    assign short_block = startup && SENSE.led_pin_short;
    assign latched_any = open_latch_ff || drain_latch_ff || seclim_latch_ff;
    assign auto_stop = SENSE.output_undervoltage_detect
                     || SENSE.current_program_over
                     || SENSE.thermal_shutdown_level
                     || short_block;
    assign all_off = lockout_ff || !ENABLE_DIM
                   || (mode_ff != fault_sup_pkg::MODE_STARTUP
                       && mode_ff != fault_sup_pkg::MODE_RUN)
                   || latched_any || auto_stop;
    assign flag_on = latched_any || auto_stop
                   || (lockout_ff && SUPPLY.regulator_alive);

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            SINK_ON <= 1'b0;
        else
            SINK_ON <= !all_off;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            BOOST_ON <= 1'b0;
        else
            BOOST_ON <= !all_off && !SENSE.output_high_threshold
                        && !SENSE.primary_switch_limit && !skip_cycle_ff;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            FAULT_N <= 1'b1;
        else
            FAULT_N <= !flag_on;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            SHUTDOWN <= 1'b0;
            MODE <= fault_sup_pkg::MODE_LOCKED;
        end
        else
        begin
            SHUTDOWN <= (nxt_mode == fault_sup_pkg::MODE_SHUTDOWN);
            MODE <= nxt_mode;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    a_open_string_latch: assert property (
        SENSE.output_high_threshold && !SENSE.led_in_regulation && !startup
        |=> open_latch_ff ##1 (!FAULT_N && !SINK_ON && !BOOST_ON))
        else $error("open string did not latch and stop");

    a_undervolt_stop: assert property (
        SENSE.output_undervoltage_detect |=> !FAULT_N && !SINK_ON && !BOOST_ON)
        else $error("output undervoltage did not stop and flag");

    a_progover_stop: assert property (
        SENSE.current_program_over |=> !FAULT_N && !SINK_ON && !BOOST_ON)
        else $error("program overcurrent did not stop and flag");

    a_overtemp_stop: assert property (
        SENSE.thermal_shutdown_level |=> !FAULT_N && !SINK_ON && !BOOST_ON)
        else $error("overtemperature did not stop and flag");

    a_drain_latched: assert property (
        drain_latch_ff && !latch_clear |=> drain_latch_ff)
        else $error("drain overvoltage latch dropped early");

    a_primary_no_flag: assert property (
        SENSE.primary_switch_limit && !flag_on
        |=> !BOOST_ON && skip_cycle_ff && FAULT_N)
        else $error("primary limit flagged or left boost on");

    a_skip_hold: assert property (
        skip_cycle_ff && !CYCLE_START |=> skip_cycle_ff && !BOOST_ON)
        else $error("skipped cycle ended before next cycle start");

    a_seclim_latch: assert property (
        SENSE.secondary_switch_limit |=> seclim_latch_ff ##1 !FAULT_N)
        else $error("secondary limit not latched");

    a_lockout_lag: assert property (
        !SUPPLY.lockout_falling_level |=> !fall_lag [*8])
        else $error("short supply dip caused lockout");

    a_locked_mode: assert property (
        lockout_ff |=> MODE == fault_sup_pkg::MODE_LOCKED && !SINK_ON)
        else $error("enabled while supply locked out");

    a_shutdown_clear: assert property (
        low_shutdown && !SENSE.drain_overvoltage_threshold
        |=> !drain_latch_ff)
        else $error("shutdown did not clear latch");

    a_lockout_clear: assert property (
        lockout_ff && !SENSE.secondary_switch_limit |=> !seclim_latch_ff
        ##1 !SINK_ON)
        else $error("lockout did not clear latch or sink");

    a_loaddump_sink: assert property (
        mode_ff == fault_sup_pkg::MODE_RUN && nxt_mode == mode_ff
        && ENABLE_DIM && !lockout_ff && !latched_any && !auto_stop
        && SENSE.output_high_threshold && SENSE.led_in_regulation
        |=> SINK_ON && !BOOST_ON && FAULT_N)
        else $error("load dump stopped sink, left boost on or flagged");

    a_enable_low_off: assert property (
        !ENABLE_DIM |=> !SINK_ON && !BOOST_ON)
        else $error("enable low left outputs on");

    a_counter_restart: assert property (
        ENABLE_DIM && !en_prev_ff
        |=> low_cnt_ff == fault_sup_pkg::LOW_CNT_ZERO)
        else $error("low counter not restarted");

    c_run_reached: cover property (mode_ff == fault_sup_pkg::MODE_RUN);
    c_latch_cleared: cover property ($fell(drain_latch_ff));
    c_lockout_seen: cover property ($rose(lockout_ff));
    c_cycle_skip: cover property ($rose(skip_cycle_ff) ##1 CYCLE_START);
    c_short_blocked: cover property (short_block);
endmodule
`default_nettype wire

// *** tb/host_model.sv ***
`default_nettype none
// host side: drives enable/dim, watches the fault flag
module host_model (
    input wire logic clk,
    input wire logic fault_n,
    output var logic en_dim
);
    timeunit 1ns;
    timeprecision 1ps;

    initial en_dim = 1'b0;

    // host view of the flag: high while the device reports a fault
    function automatic logic flag_raised();
        return !fault_n;
    endfunction

    task automatic set_en(input logic v);
        @(negedge clk);
        en_dim = v;
    endtask

    // long low to clear latched faults; caller raises it again
    task automatic hold_low(input int n);
        set_en(1'b0);
        repeat (n) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic en, cs, ssd, bo, so, fn, sd;
    fault_sup_pkg::sense_t sn;
    fault_sup_pkg::supply_t sp;
    fault_sup_pkg::mode_t md;
    int error_cnt = 0;
    int cmp_count = 0;

    always #10 clk = ~clk;

    led_fault_supervisor #(
        .SHUTDOWN_CYCLES(20'h00014),
        .CLEAR_CYCLES(20'h00028)
    ) led_fault_supervisor_i (
        .REF_CLK(clk), .RESET(rst), .ENABLE_DIM(en), .SENSE(sn),
        .SUPPLY(sp), .CYCLE_START(cs), .SOFT_START_DONE(ssd),
        .BOOST_ON(bo), .SINK_ON(so), .FAULT_N(fn), .SHUTDOWN(sd),
        .MODE(md)
    );

    host_model host_model_i (.clk(clk), .fault_n(fn), .en_dim(en));

    task automatic end_of_test();
        if (error_cnt == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic supply(input logic r, input logic f, input logic a);
        sp = '{lockout_rising_level: r, lockout_falling_level: f,
               regulator_alive: a};
    endtask

    task automatic chk(input string n, input logic [3:0] e,
                       input logic [3:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic outs(input logic b, input logic s, input logic f);
        chk("boost_on", {3'h0, b}, {3'h0, bo});
        chk("sink_on", {3'h0, s}, {3'h0, so});
        chk("fault_n", {3'h0, f}, {3'h0, fn});
    endtask

    task automatic wait_run();
        int i;
        for (i = 0; i < 200 && md !== fault_sup_pkg::MODE_RUN; i++)
            cyc(1);
        cyc(2);
    endtask

    task automatic t_up();
        host_model_i.set_en(1'b1);
        cyc(10);
        chk("mode", fault_sup_pkg::MODE_LOCKED, md);
        supply(1'b1, 1'b0, 1'b1);
        wait_run();
        chk("mode", fault_sup_pkg::MODE_RUN, md);
        outs(1'b1, 1'b1, 1'b1);
    endtask

    task automatic t_dim();
        host_model_i.set_en(1'b0);
        cyc(3);
        outs(1'b0, 1'b0, 1'b1);
        cyc(12);
        host_model_i.set_en(1'b1);
        host_model_i.set_en(1'b0);
        cyc(15);
        chk("shutdown", 4'h0, {3'h0, sd});
        host_model_i.set_en(1'b1);
        wait_run();
        outs(1'b1, 1'b1, 1'b1);
    endtask

    task automatic t_auto();
        logic [8:0] m[3];
        m = '{9'h040, 9'h004, 9'h002};
        foreach (m[i])
        begin
            sn = m[i];
            cyc(3);
            outs(1'b0, 1'b0, 1'b0);
            sn = '0;
            wait_run();
            outs(1'b1, 1'b1, 1'b1);
        end
    endtask

    task automatic t_dump_prim();
        sn = '{output_high_threshold: 1'b1, led_in_regulation: 1'b1,
               default: 1'b0};
        cyc(3);
        outs(1'b0, 1'b1, 1'b1);
        sn = '0;
        cyc(3);
        outs(1'b1, 1'b1, 1'b1);
        sn = '{primary_switch_limit: 1'b1, default: 1'b0};
        cyc(1);
        sn = '0;
        cyc(5);
        outs(1'b0, 1'b1, 1'b1);
        cs = 1'b1;
        cyc(1);
        cs = 1'b0;
        cyc(2);
        outs(1'b1, 1'b1, 1'b1);
    endtask

    task automatic t_latch();
        logic [8:0] m[3];
        m = '{9'h008, 9'h020, 9'h100};
        foreach (m[i])
        begin
            sn = m[i];
            cyc(1);
            sn = '0;
            cyc(10);
            outs(1'b0, 1'b0, 1'b0);
            chk("host_flag", 4'h1,
                {3'h0, host_model_i.flag_raised()});
            host_model_i.hold_low(45);
            chk("shutdown", 4'h1, {3'h0, sd});
            outs(1'b0, 1'b0, 1'b1);
            host_model_i.set_en(1'b1);
            wait_run();
            outs(1'b1, 1'b1, 1'b1);
        end
    endtask

    task automatic t_supply_lockout();
        supply(1'b1, 1'b1, 1'b1);
        cyc(30);
        supply(1'b1, 1'b0, 1'b1);
        cyc(2);
        chk("mode", fault_sup_pkg::MODE_RUN, md);
        sn = '{secondary_switch_limit: 1'b1, default: 1'b0};
        cyc(1);
        sn = '0;
        supply(1'b0, 1'b1, 1'b1);
        cyc(56);
        chk("mode", fault_sup_pkg::MODE_LOCKED, md);
        outs(1'b0, 1'b0, 1'b0);
        supply(1'b0, 1'b1, 1'b0);
        cyc(3);
        outs(1'b0, 1'b0, 1'b1);
        supply(1'b1, 1'b0, 1'b1);
        wait_run();
        outs(1'b1, 1'b1, 1'b1);
    endtask

    task automatic t_short();
        host_model_i.hold_low(25);
        sn = '{led_pin_short: 1'b1, default: 1'b0};
        ssd = 1'b0;
        host_model_i.set_en(1'b1);
        cyc(5);
        chk("mode", fault_sup_pkg::MODE_STARTUP, md);
        outs(1'b0, 1'b0, 1'b0);
        sn = '{output_high_threshold: 1'b1, default: 1'b0};
        cyc(2);
        sn = '0;
        ssd = 1'b1;
        wait_run();
        outs(1'b1, 1'b1, 1'b1);
    endtask

    initial
    begin
        cs = 1'b0;
        ssd = 1'b1;
        sn = '0;
        supply(1'b0, 1'b0, 1'b1);
        cyc(20);
        rst = 1'b0;
        t_up();
        t_dim();
        t_auto();
        t_dump_prim();
        t_latch();
        t_supply_lockout();
        t_short();
        end_of_test();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
endmodule
`default_nettype wire
